// ### logic/tsense_pkg.sv
// Register offsets, field positions and reset values of the sensor bank
`default_nettype none
package tsense_pkg;
    // ************************************************
    // Read pointers
    // ************************************************
    localparam logic [7:0] RD_LOC_HI   = 8'h00;
    localparam logic [7:0] RD_REM_HI   = 8'h01;
    localparam logic [7:0] RD_STATUS   = 8'h02;
    localparam logic [7:0] RD_CONFIG   = 8'h03;
    localparam logic [7:0] RD_RATE     = 8'h04;
    localparam logic [7:0] RD_LHLIM    = 8'h05;
    localparam logic [7:0] RD_LLLIM    = 8'h06;
    localparam logic [7:0] RD_RHLIM_U  = 8'h07;
    localparam logic [7:0] RD_RLLIM_U  = 8'h08;
    localparam logic [7:0] RD_REM_LO   = 8'h10;
    localparam logic [7:0] RD_LOC_LO   = 8'h15;
    localparam logic [7:0] RD_ID       = 8'hFE;
    // ************************************************
    // Write pointers that differ from the read ones
    // ************************************************
    localparam logic [7:0] WR_CONFIG   = 8'h09;
    localparam logic [7:0] WR_RATE     = 8'h0A;
    localparam logic [7:0] WR_LHLIM    = 8'h0B;
    localparam logic [7:0] WR_LLLIM    = 8'h0C;
    localparam logic [7:0] WR_RHLIM_U  = 8'h0D;
    localparam logic [7:0] WR_RLLIM_U  = 8'h0E;
    localparam logic [7:0] WR_ONESHOT  = 8'h0F;
    // Same pointer for read and write
    localparam logic [7:0] RW_ROFS_U   = 8'h11;
    localparam logic [7:0] RW_ROFS_L   = 8'h12;
    localparam logic [7:0] RW_RHLIM_L  = 8'h13;
    localparam logic [7:0] RW_RLLIM_L  = 8'h14;
    localparam logic [7:0] RW_RTHLIM   = 8'h19;
    localparam logic [7:0] RW_LTHLIM   = 8'h20;
    localparam logic [7:0] RW_HYST     = 8'h21;
    localparam logic [7:0] RW_ALCNT    = 8'h22;
    localparam logic [7:0] RW_IDEAL    = 8'h23;
    localparam logic [7:0] RW_FILT     = 8'h24;
    // ************************************************
    // Reset values and fields
    // ************************************************
    localparam logic [7:0] PTR_RST     = 8'h00;
    localparam logic [7:0] CFG_RST     = 8'h00;
    localparam logic [7:0] CFG_WMASK   = 8'hE4;
    localparam logic [7:0] RATE_RST    = 8'h80;
    localparam logic [7:0] LHLIM_RST   = 8'h55;
    localparam logic [7:0] RTHLIM_RST  = 8'h6C;
    localparam logic [7:0] LTHLIM_RST  = 8'h55;
    localparam logic [7:0] HYST_RST    = 8'h0A;
    localparam logic [7:0] ALCNT_RST   = 8'h01;
    localparam logic [7:0] ALCNT_FIXED = 8'h01;
    localparam logic [7:0] ZERO8       = 8'h00;
    localparam logic [3:0] NIB0        = 4'h0;
    localparam int CFG_MASK_BIT = 7;
    localparam int CFG_SHUTDOWN_BIT = 6;
    localparam int CFG_ROLE_BIT = 5;
endpackage : tsense_pkg
`default_nettype wire

// ### logic/tsense_regs.sv
// Register bank, result locking and alarm outputs of the sensor
`default_nettype none
module tsense_regs
    import tsense_pkg::*;
#(
    parameter logic [7:0] MAKER_ID = 8'hA5  // Arbitrary identity value
)(
    input  wire logic        clock,
    input  wire logic        sys_rst,
    input  wire logic        wr_valid,     // Received write byte
    input  wire logic        wr_first,     // It is the first byte
    input  wire logic [7:0]  wr_data,
    input  wire logic        rd_req,       // Master wants a byte
    input  wire logic        addr_read,    // Alert response read
    input  wire logic        conv_done,    // Conversion finished
    input  wire logic [11:0] local_result,
    input  wire logic [11:0] remote_result,
    input  wire logic        remote_open,  // Open remote sensor
    input  wire logic        conv_busy,
    output logic [7:0]       rd_data_r,
    output logic             rd_valid_r,
    output logic             oneshot_start_r,
    output logic             conv_enable_r,
    output logic             alert_out_n_r, // Shared pin
    output logic             thermal_out_n_r
);
    // ************************************************
    // Storage
    // ************************************************
    logic [7:0] pointer_r;                 // Register select
    logic [7:0] loc_hi_r, loc_lo_r;        // Local result
    logic [7:0] rem_hi_r, rem_lo_r;        // Remote result
    logic [7:0] config_r, rate_r;
    logic [7:0] lhlim_r, lllim_r;
    logic [7:0] rhlim_u_r, rllim_u_r, rhlim_l_r, rllim_l_r;
    logic [7:0] rofs_u_r, rofs_l_r;        // Offset, stored and read back only
    logic [7:0] rthlim_r, lthlim_r, hyst_r;
    logic [7:0] alcnt_r, ideal_r, filt_r;
    logic       hold_loc_lo_r, hold_loc_hi_r; // Companion locks
    logic       hold_rem_lo_r, hold_rem_hi_r;
    logic [4:0] flags_r;                   // LH LL RH RL OPEN
    logic       loc_therm_r, rem_therm_r;  // Thermal flags
    logic       th2_r;                     // Second thermal state
    logic       alert_latch_r;
    logic       oneshot_run_r;             // Single conversion live

    // ************************************************
    // Decode
    // ************************************************
    wire data_wr = wr_valid && !wr_first;
    function automatic logic hit(input logic [7:0] ptr,
                                 input logic [7:0] adr);
        hit = (ptr == adr);
    endfunction
    wire rd_loc_hi = rd_req && hit(pointer_r, RD_LOC_HI);
    wire rd_loc_lo = rd_req && hit(pointer_r, RD_LOC_LO);
    wire rd_rem_hi = rd_req && hit(pointer_r, RD_REM_HI);
    wire rd_rem_lo = rd_req && hit(pointer_r, RD_REM_LO);
    wire rd_stat   = rd_req && hit(pointer_r, RD_STATUS);
    // A read of any other register drops both channel locks
    wire rd_other_loc = rd_req && !rd_loc_hi && !rd_loc_lo;
    wire rd_other_rem = rd_req && !rd_rem_hi && !rd_rem_lo;
    wire wr_oneshot = data_wr && hit(pointer_r, WR_ONESHOT);
    wire shut = config_r[CFG_SHUTDOWN_BIT];
    wire role_th2 = config_r[CFG_ROLE_BIT];
    wire alert_mask = config_r[CFG_MASK_BIT];

    // ************************************************
    // Twelve-bit comparisons
    // ************************************************
    wire [11:0] loc_t = {loc_hi_r, loc_lo_r[7:4]};
    wire [11:0] rem_t = {rem_hi_r, rem_lo_r[7:4]};
    wire [11:0] lhl = {lhlim_r, NIB0};
    wire [11:0] lll = {lllim_r, NIB0};
    wire [11:0] rhl = {rhlim_u_r, rhlim_l_r[7:4]};
    wire [11:0] rll = {rllim_u_r, rllim_l_r[7:4]};
    wire [11:0] lth = {lthlim_r, NIB0};
    wire [11:0] rth = {rthlim_r, NIB0};
    wire [11:0] hys = {hyst_r, NIB0};
    // Clamp at zero so a large hysteresis cannot wrap round
    wire [11:0] lth_rel = (hys > lth) ? 12'h000 : lth - hys;
    wire [11:0] rth_rel = (hys > rth) ? 12'h000 : rth - hys;
    wire [11:0] lhl_rel = (hys > lhl) ? 12'h000 : lhl - hys;
    wire [11:0] rhl_rel = (hys > rhl) ? 12'h000 : rhl - hys;
    wire c_lh = loc_t > lhl;
    wire c_ll = loc_t < lll;
    wire c_rh = rem_t > rhl;
    wire c_rl = rem_t < rll;
    wire [4:0] cond = {c_lh, c_ll, c_rh, c_rl, remote_open};

    // ************************************************
    // Next values
    // ************************************************
    // Hardware set beats a status-read clear of the same flag
    wire [4:0] flags_nxt = cond |
        (flags_r & ~({5{rd_stat}} & ~cond));
    wire loc_therm_nxt = (loc_t > lth) ||
        (loc_therm_r && (loc_t > lth_rel));
    wire rem_therm_nxt = (rem_t > rth) ||
        (rem_therm_r && (rem_t > rth_rel));
    wire th2_nxt = c_lh || c_rh || (th2_r &&
        ((loc_t > lhl_rel) || (rem_t > rhl_rel)));
    wire quiet = (flags_r == 5'h00) && (cond == 5'h00);
    wire latch_nxt = (!role_th2 && (cond != 5'h00 || flags_r != 5'h00))
        || (alert_latch_r && !(addr_read && quiet));
    wire [7:0] status_v = {conv_busy, flags_r,
                           rem_therm_r, loc_therm_r};
    logic [7:0] rd_mux;
    always_comb
    begin
        case (pointer_r)
            RD_LOC_HI:  rd_mux = loc_hi_r;
            RD_LOC_LO:  rd_mux = {loc_lo_r[7:4], NIB0};
            RD_REM_HI:  rd_mux = rem_hi_r;
            RD_REM_LO:  rd_mux = {rem_lo_r[7:4], NIB0};
            RD_STATUS:  rd_mux = status_v;
            RD_CONFIG:  rd_mux = config_r;
            RD_RATE:    rd_mux = rate_r;
            RD_LHLIM:   rd_mux = lhlim_r;
            RD_LLLIM:   rd_mux = lllim_r;
            RD_RHLIM_U: rd_mux = rhlim_u_r;
            RD_RLLIM_U: rd_mux = rllim_u_r;
            RW_ROFS_U:  rd_mux = rofs_u_r;
            RW_ROFS_L:  rd_mux = rofs_l_r;
            RW_RHLIM_L: rd_mux = rhlim_l_r;
            RW_RLLIM_L: rd_mux = rllim_l_r;
            RW_RTHLIM:  rd_mux = rthlim_r;
            RW_LTHLIM:  rd_mux = lthlim_r;
            RW_HYST:    rd_mux = hyst_r;
            RW_ALCNT:   rd_mux = alcnt_r | ALCNT_FIXED;
            RW_IDEAL:   rd_mux = ideal_r;
            RW_FILT:    rd_mux = filt_r;
            RD_ID:      rd_mux = MAKER_ID;
            default:    rd_mux = ZERO8;               // Unmapped reads 0
        endcase
    end

    // ************************************************
    // Pointer and writable registers
    // ************************************************
    // Low nibbles of fraction registers are kept as zero
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            pointer_r <= PTR_RST;
            config_r  <= CFG_RST;
            rate_r    <= RATE_RST;
            lhlim_r   <= LHLIM_RST;
            lllim_r   <= ZERO8;
            rhlim_u_r <= ZERO8;
            rllim_u_r <= ZERO8;
            rhlim_l_r <= ZERO8;
            rllim_l_r <= ZERO8;
            rofs_u_r  <= ZERO8;
            rofs_l_r  <= ZERO8;
            rthlim_r  <= RTHLIM_RST;
            lthlim_r  <= LTHLIM_RST;
            hyst_r    <= HYST_RST;
            alcnt_r   <= ALCNT_RST;
            ideal_r   <= ZERO8;
            filt_r    <= ZERO8;
        end
        else if (wr_valid && wr_first)
            pointer_r <= wr_data;
        else if (data_wr)
        begin
            // Result and status pointers are not writable
            case (pointer_r)
                WR_CONFIG:  config_r  <= wr_data & CFG_WMASK;
                WR_RATE:    rate_r    <= wr_data;
                WR_LHLIM:   lhlim_r   <= wr_data;
                WR_LLLIM:   lllim_r   <= wr_data;
                WR_RHLIM_U: rhlim_u_r <= wr_data;
                WR_RLLIM_U: rllim_u_r <= wr_data;
                RW_ROFS_U:  rofs_u_r  <= wr_data;
                RW_ROFS_L:  rofs_l_r  <= {wr_data[7:4], NIB0};
                RW_RHLIM_L: rhlim_l_r <= {wr_data[7:4], NIB0};
                RW_RLLIM_L: rllim_l_r <= {wr_data[7:4], NIB0};
                RW_RTHLIM:  rthlim_r  <= wr_data;
                RW_LTHLIM:  lthlim_r  <= wr_data;
                RW_HYST:    hyst_r    <= wr_data;
                RW_ALCNT:   alcnt_r   <= wr_data;
                RW_IDEAL:   ideal_r   <= wr_data;
                RW_FILT:    filt_r    <= wr_data;
                default:    ;                         // 0F not stored
            endcase
        end
    end

    // ************************************************
    // Byte-pair locks
    // ************************************************
    // Reading the companion or another register ends the lock
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            hold_loc_lo_r <= 1'b0;
            hold_loc_hi_r <= 1'b0;
            hold_rem_lo_r <= 1'b0;
            hold_rem_hi_r <= 1'b0;
        end
        else
        begin
            if (rd_loc_hi)
            begin
                hold_loc_lo_r <= !hold_loc_hi_r;
                hold_loc_hi_r <= 1'b0;
            end
            else if (rd_loc_lo)
            begin
                hold_loc_hi_r <= !hold_loc_lo_r;
                hold_loc_lo_r <= 1'b0;
            end
            else if (rd_other_loc)
            begin
                hold_loc_lo_r <= 1'b0;
                hold_loc_hi_r <= 1'b0;
            end
            if (rd_rem_hi)
            begin
                hold_rem_lo_r <= !hold_rem_hi_r;
                hold_rem_hi_r <= 1'b0;
            end
            else if (rd_rem_lo)
            begin
                hold_rem_hi_r <= !hold_rem_lo_r;
                hold_rem_lo_r <= 1'b0;
            end
            else if (rd_other_rem)
            begin
                hold_rem_lo_r <= 1'b0;
                hold_rem_hi_r <= 1'b0;
            end
        end
    end

    // ************************************************
    // Result registers
    // ************************************************
    // A locked byte skips every conversion until released so the pair stays matched
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            loc_hi_r <= ZERO8;
            loc_lo_r <= ZERO8;
            rem_hi_r <= ZERO8;
            rem_lo_r <= ZERO8;
        end
        else if (conv_done)
        begin
            if (!hold_loc_hi_r)
                loc_hi_r <= local_result[11:4];
            if (!hold_loc_lo_r)
                loc_lo_r <= {local_result[3:0], NIB0};
            if (!hold_rem_hi_r)
                rem_hi_r <= remote_result[11:4];
            if (!hold_rem_lo_r)
                rem_lo_r <= {remote_result[3:0], NIB0};
        end
    end

    // ************************************************
    // Flags, latch and pins
    // ************************************************
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            flags_r         <= 5'h00;
            loc_therm_r     <= 1'b0;
            rem_therm_r     <= 1'b0;
            th2_r           <= 1'b0;
            alert_latch_r   <= 1'b0;
            alert_out_n_r   <= 1'b1;
            thermal_out_n_r <= 1'b1;
        end
        else
        begin
            flags_r         <= flags_nxt;
            loc_therm_r     <= loc_therm_nxt;
            rem_therm_r     <= rem_therm_nxt;
            th2_r           <= th2_nxt;
            alert_latch_r   <= latch_nxt;
            thermal_out_n_r <= !(loc_therm_nxt || rem_therm_nxt);
            // Pin role picks its source; mask counts in alert mode only
            alert_out_n_r   <= role_th2 ? !th2_nxt
                             : !(latch_nxt && !alert_mask);
        end
    end

    // ************************************************
    // Read answer and conversion control
    // ************************************************
    // Answer comes one cycle after the request
    always_ff @(posedge clock or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            rd_data_r       <= ZERO8;
            rd_valid_r      <= 1'b0;
            oneshot_start_r <= 1'b0;
            oneshot_run_r   <= 1'b0;
            conv_enable_r   <= 1'b1;
        end
        else
        begin
            rd_valid_r      <= rd_req;
            if (rd_req)
                rd_data_r   <= rd_mux;
            oneshot_start_r <= wr_oneshot;
            if (wr_oneshot && shut)
                oneshot_run_r <= 1'b1;
            else if (conv_done)
                oneshot_run_r <= 1'b0;
            conv_enable_r <= !shut || (wr_oneshot && shut) ||
                             (oneshot_run_r && !conv_done);
        end
    end

    // ************************************************
    // Checks
    // ************************************************
    default clocking cb @(posedge clock); endclocking
    default disable iff (sys_rst);

    a_pointer_load: assert property (wr_valid && wr_first |=>
        pointer_r == $past(wr_data)) else $error("pointer");
    a_read_answer: assert property (rd_req |=> rd_valid_r &&
        rd_data_r == $past(rd_mux)) else $error("read");
    // A locked local low byte must ride out any conversion unchanged
    a_lock_holds: assert property (hold_loc_lo_r && conv_done |=>
        $stable(loc_lo_r)) else $error("lock");
    a_lock_release: assert property (rd_stat |=> !hold_loc_lo_r &&
        !hold_rem_lo_r) else $error("unlock");
    a_flag_keep: assert property (rd_stat && c_lh |=> flags_r[4])
        else $error("flag cleared");
    a_flag_clear: assert property (rd_stat && !c_lh |=>
        flags_r[4] == 1'b0) else $error("flag stuck");
    a_latch_hold: assert property (alert_latch_r && !addr_read
        |=> alert_latch_r) else $error("latch");
    a_alert_drive: assert property (!role_th2 && !alert_mask
        && cond != 5'h00 |=> !alert_out_n_r) else $error("alert");
    a_mask_alert: assert property (!role_th2 && alert_mask
        |=> alert_out_n_r || $past(!config_r[CFG_MASK_BIT]))
        else $error("mask");
    a_therm_out: assert property (loc_t > lth |=>
        !thermal_out_n_r && loc_therm_r) else $error("therm");
    a_oneshot: assert property (wr_oneshot |=> oneshot_start_r
        ##1 !oneshot_start_r || wr_oneshot) else $error("oneshot");
    c_lock_pair: cover property (rd_loc_hi ##[1:4] rd_loc_lo);
    c_alert_clear: cover property (alert_latch_r ##1 !alert_latch_r);
    c_th2_mode: cover property (role_th2 && !alert_out_n_r);
    c_oneshot: cover property (oneshot_run_r ##[1:50] conv_done);
endmodule // tsense_regs
`default_nettype wire

// ### bench/bus_master.sv
// Behavioural two-wire master as seen at the register port of the bank
`default_nettype none
module bus_master (
    input  wire logic       clock,
    output logic            wr_valid,
    output logic            wr_first,
    output logic [7:0]      wr_data,
    output logic            rd_req,
    output logic            addr_read
);
    timeunit 1ns;
    timeprecision 1ps;
    // ************************************************
    // Idle bus
    // ************************************************
    // No strobes; data bus starts on a pattern, not a value of use
    initial
    begin
        wr_valid  = 1'b0;
        wr_first  = 1'b0;
        wr_data   = 8'hA5;
        rd_req    = 1'b0;
        addr_read = 1'b0;
    end
    // ************************************************
    // Transactions, all launched at the falling edge
    // ************************************************
    // Pointer byte, then an optional data byte in the same transaction
    task automatic wr(input logic [7:0] p, input logic [7:0] d,
                      input bit has_d);
        @(negedge clock);
        wr_valid = 1'b1;
        wr_first = 1'b1;
        wr_data  = p;
        if (has_d)
        begin
            @(negedge clock);
            wr_first = 1'b0;
            wr_data  = d;
        end
        @(negedge clock);
        wr_valid = 1'b0;
        wr_first = 1'b0;
        // Released bus shows the inverse, so stale data never matches
        wr_data  = ~wr_data;
    endtask
    // One byte read at whatever the pointer holds
    task automatic rd();
        @(negedge clock);
        rd_req = 1'b1;
        @(negedge clock);
        rd_req = 1'b0;
    endtask
    // Alert response: the master reads the device address
    task automatic ara();
        @(negedge clock);
        addr_read = 1'b1;
        @(negedge clock);
        addr_read = 1'b0;
    endtask
endmodule // bus_master
`default_nettype wire

// ### bench/tb_temp_sensor_register_alert.sv
// Self-checking bench for the sensor register bank and alarm pins
`default_nettype none
module tb_temp_sensor_register_alert
    import tsense_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0] ID_VAL = 8'h3C; // Arbitrary identity value
    logic        clock, sys_rst, wr_valid, wr_first, rd_req, addr_read;
    logic        conv_done, remote_open, conv_busy, rd_valid_r;
    logic        oneshot_start_r, conv_enable_r;
    logic        alert_out_n_r, thermal_out_n_r;
    logic [7:0]  wr_data, rd_data_r;
    logic [11:0] local_result, remote_result, l, r;
    logic [7:0]  exp_q[$];              // Expected read bytes, oldest first
    int          n_mismatch, comparisons;
    integer      seed;
    // Reset table: pointer and expected value, unmapped 30h last
    logic [7:0] rp [13] = '{8'h00, 8'h01, 8'h03, 8'h04, 8'h05, 8'h10,
        8'h15, 8'h19, 8'h20, 8'h21, 8'h22, 8'hFE, 8'h30};
    logic [7:0] rv [13] = '{8'h00, 8'h00, CFG_RST, RATE_RST, LHLIM_RST,
        8'h00, 8'h00, RTHLIM_RST, LTHLIM_RST, HYST_RST, ALCNT_RST,
        ID_VAL, 8'h00};
    tsense_regs #(.MAKER_ID(ID_VAL)) i_tsense_regs (
        .clock(clock), .sys_rst(sys_rst), .wr_valid(wr_valid),
        .wr_first(wr_first), .wr_data(wr_data), .rd_req(rd_req),
        .addr_read(addr_read), .conv_done(conv_done),
        .local_result(local_result), .remote_result(remote_result),
        .remote_open(remote_open), .conv_busy(conv_busy),
        .rd_data_r(rd_data_r), .rd_valid_r(rd_valid_r),
        .oneshot_start_r(oneshot_start_r), .conv_enable_r(conv_enable_r),
        .alert_out_n_r(alert_out_n_r), .thermal_out_n_r(thermal_out_n_r));
    bus_master i_bus_master (.clock(clock), .wr_valid(wr_valid),
        .wr_first(wr_first), .wr_data(wr_data), .rd_req(rd_req),
        .addr_read(addr_read));
    // ************************************************
    // Clock, checking and closing
    // ************************************************
    initial
    begin
        clock = 1'b0;
        forever #5 clock = ~clock;
    end
    task automatic chk_byte(input logic [7:0] e, input logic [7:0] g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH rd_data_r exp %h got %h", e, g);
        end
    endtask
    task automatic chk_pin(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            n_mismatch++;
            $display("MISMATCH %s exp %b got %b", n, e, g);
        end
    endtask
    // Read data is settled by the falling edge after the pulse launches
    always @(negedge clock)
        if (rd_valid_r === 1'b1)
            chk_byte(exp_q.size() ? exp_q.pop_front() : 8'hXX,
                     rd_data_r);
    task automatic wrap_up();
        // A read that never answered leaves its note behind
        if (exp_q.size() != 0)
        begin
            n_mismatch++;
            $display("MISMATCH unanswered_reads exp 0 got %0d",
                     exp_q.size());
        end
        $display("comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0)
            $display("== PASSED ==");
        else
            $display("== FAILED ==");
        $finish;
    endtask
    // Watchdog: the sequence needs well under a thousand cycles
    initial
    begin
        repeat (5000) @(posedge clock);
        n_mismatch++;
        wrap_up();
    end
    // ************************************************
    // Stimulus helpers
    // ************************************************
    task automatic rdc(input logic [7:0] e);
        exp_q.push_back(e);
        i_bus_master.rd();
    endtask
    task automatic rdp(input logic [7:0] p, input logic [7:0] e);
        i_bus_master.wr(p, 8'h00, 1'b0);
        rdc(e);
    endtask
    // One conversion, then two edges for flags and pins to follow
    task automatic cv(input logic [11:0] lv, input logic [11:0] rv2);
        @(negedge clock);
        local_result  = lv;
        remote_result = rv2;
        conv_done     = 1'b1;
        @(negedge clock);
        conv_done = 1'b0;
        repeat (2) @(negedge clock);
    endtask
    task automatic pins(input logic a, input logic t);
        chk_pin("alert_out_n_r", a, alert_out_n_r);
        chk_pin("thermal_out_n_r", t, thermal_out_n_r);
    endtask
    // ************************************************
    // Main sequence
    // ************************************************
    initial
    begin
        seed = 32'h07a6efd7;
        sys_rst = 1'b1;
        conv_done = 1'b0;
        local_result = 12'h000;
        remote_result = 12'h000;
        remote_open = 1'b0;
        conv_busy = 1'b0;
        repeat (5) @(posedge clock);
        @(negedge clock);
        sys_rst = 1'b0;
        rdc(8'h00);
        foreach (rp[k]) rdp(rp[k], rv[k]);
        i_bus_master.wr(8'h00, 8'hFF, 1'b1);
        rdp(8'h00, 8'h00);
        i_bus_master.wr(WR_CONFIG, 8'hFF, 1'b1);
        rdp(8'h03, CFG_WMASK);
        i_bus_master.wr(WR_CONFIG, 8'h00, 1'b1);
        i_bus_master.wr(8'h0D, 8'h30, 1'b1);
        i_bus_master.wr(8'h13, 8'h80, 1'b1);
        rdp(8'h13, 8'h80);
        // Random results kept inside all the limits
        repeat (3)
        begin
            l = 12'h200 | 12'($random(seed) & 255);
            r = 12'h100 | 12'($random(seed) & 255);
            cv(l, r);
            rdp(8'h00, l[11:4]);
            rdp(8'h15, {l[3:0], 4'h0});
            rdp(8'h01, r[11:4]);
            rdp(8'h10, {r[3:0], 4'h0});
        end
        // High byte read freezes the low byte until another read
        rdp(8'h00, l[11:4]);
        cv(l ^ 12'h015, r);
        rdp(8'h15, {l[3:0], 4'h0});
        rdp(8'h02, 8'h00);
        cv(l ^ 12'h00A, r);
        rdp(8'h15, {l[3:0] ^ 4'hA, 4'h0});
        conv_busy = 1'b1;
        rdp(8'h02, 8'h80);
        conv_busy = 1'b0;
        // Alert mode: over limit, hysteresis, then service
        cv(12'h560, 12'h100);
        pins(1'b0, 1'b0);
        i_bus_master.ara();
        repeat (2) @(negedge clock);
        pins(1'b0, 1'b0);
        rdp(8'h02, 8'h41);
        cv(12'h500, 12'h100);
        pins(1'b0, 1'b0);
        rdp(8'h02, 8'h41);
        rdc(8'h01);
        cv(12'h4B0, 12'h100);
        pins(1'b0, 1'b1);
        rdc(8'h00);
        i_bus_master.ara();
        repeat (2) @(negedge clock);
        pins(1'b1, 1'b1);
        // Masked alert keeps the pin high
        i_bus_master.wr(WR_CONFIG, 8'h80, 1'b1);
        cv(12'h560, 12'h100);
        pins(1'b1, 1'b0);
        cv(12'h200, 12'h100);
        rdp(8'h02, 8'h40);
        rdc(8'h00);
        i_bus_master.ara();
        // Second thermal role: high limits only, mask ignored
        i_bus_master.wr(WR_CONFIG, 8'hA0, 1'b1);
        i_bus_master.wr(WR_LLLIM, 8'h30, 1'b1);
        cv(12'h200, 12'h308);
        pins(1'b1, 1'b1);
        cv(12'h200, 12'h309);
        pins(1'b0, 1'b1);
        rdp(8'h02, 8'h30);
        cv(12'h200, 12'h269);
        pins(1'b0, 1'b1);
        cv(12'h200, 12'h268);
        pins(1'b1, 1'b1);
        // Shutdown plus single conversion
        i_bus_master.wr(WR_CONFIG, 8'h40, 1'b1);
        i_bus_master.wr(WR_ONESHOT, 8'($random(seed)), 1'b1);
        chk_pin("oneshot_start_r", 1'b1, oneshot_start_r);
        chk_pin("conv_enable_r", 1'b1, conv_enable_r);
        cv(12'h200, 12'h268);
        chk_pin("conv_enable_r", 1'b0, conv_enable_r);
        // Open remote sensor: flag sticks until read after it goes away
        remote_open = 1'b1;
        rdp(8'h02, 8'h34);
        remote_open = 1'b0;
        rdc(8'h24);
        rdc(8'h20);
        repeat (3) @(negedge clock);
        wrap_up();
    end
endmodule // tb_temp_sensor_register_alert
`default_nettype wire
